// File: test_two_level_interrupt_controller.sv
// Purpose: Self-checking bench for the two-level interrupt controller
// Assumes: Zero-wait APB slave; core model fetches vectors
// Notes: Every expected vector is queued before the core fetches it
`timescale 1ns/10ps
`default_nettype none
module test_two_level_interrupt_controller;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  tlic_pkg::tlic_evt_t evt;
  logic [3:0] ext_a_pin;
  logic [1:0] ext_b_pin;
  tlic_pkg::tlic_irq_t irq;
  logic irq_ack;
  logic return_from_interrupt;
  logic instr_done;
  logic wake;
  logic accept;
  logic took;
  logic [15:0] took_vec;
  logic [15:0] exp_q[$];
  logic [31:0] lfsr = 32'h12ff;
  logic [31:0] rd;
  logic err;
  int miscompares = 0;
  int check_count = 0;
  int acks = 0;
  int base;
  int s;
  localparam logic [15:0] EXPV [9] = '{16'h0003, 16'h000b, 16'h001b,
    16'h0023, 16'h002b, 16'h0033, 16'h0043, 16'h004b, 16'h0053};
  localparam logic [8:0] EVB [9] = '{9'h000, 9'h100, 9'h080, 9'h020,
    9'h040, 9'h004, 9'h002, 9'h001, 9'h000};
  localparam logic [7:0] RADR [7] = '{8'ha8, 8'hb8, 8'hac, 8'hbc,
    8'hc0, 8'hc4, 8'hc8};

  always #12.5 ref_clk = ~ref_clk;

  tlic_top #(.NA(4), .NB(2)) tlic_top_i (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .evt(evt),
    .ext_a_pin(ext_a_pin), .ext_b_pin(ext_b_pin), .irq(irq),
    .irq_ack(irq_ack), .return_from_interrupt(return_from_interrupt),
    .instr_done(instr_done), .wake(wake));

  tlic_core_model tlic_core_model_i (
    .ref_clk(ref_clk), .rst(rst), .irq(irq), .accept(accept),
    .irq_ack(irq_ack), .took(took), .took_vec(took_vec));

  // ***********************
  // Shared tasks
  // ***********************
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    lfsr_next = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    if (miscompares == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic ticks(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Request held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic pulse(input logic [8:0] m);
    @(posedge ref_clk);
    evt <= tlic_pkg::tlic_evt_t'(m);
    @(posedge ref_clk);
    evt <= '0;
  endtask

  task automatic wait_req();
    int n;
    n = 0;
    while (irq.req !== 1'b1 && n < 40) begin
      @(posedge ref_clk);
      n++;
    end
  endtask

  task automatic wait_acks(input int k);
    int n;
    n = 0;
    while (acks < k && n < 60) begin
      @(posedge ref_clk);
      n++;
    end
  endtask

  // Return, then nothing may be served before one main instruction
  task automatic ret_seq();
    @(posedge ref_clk);
    return_from_interrupt <= 1'b1;
    @(posedge ref_clk);
    return_from_interrupt <= 1'b0;
    ticks(3);
    check(32'(irq.req), 32'h0);
    instr_done <= 1'b1;
    @(posedge ref_clk);
    instr_done <= 1'b0;
  endtask

  always @(posedge ref_clk) begin
    if (took === 1'b1) begin
      acks++;
      if (exp_q.size() == 0)
        check(32'(took_vec), 32'hffffffff);
      else
        check(32'(took_vec), 32'(exp_q.pop_front()));
    end
  end

  initial begin
    ticks(8000);
    miscompares++;
    close_out();
  end

  // ***********************
  // Scenarios
  // ***********************
  initial begin
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h0;
    evt <= '0;
    ext_a_pin <= 4'h0;
    ext_b_pin <= 2'h0;
    return_from_interrupt <= 1'b0;
    instr_done <= 1'b0;
    accept <= 1'b1;
    ticks(20);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, RADR[i], 32'h0);
      check(rd, 32'h0);
    end
    apb(1'b0, 8'h10, 32'h0);
    check(32'(err), 32'h1);
    check(rd, 32'h0);
    apb(1'b1, 8'ha8, 32'h7f);
    apb(1'b1, 8'hac, 32'h0e);
    apb(1'b1, 8'hc4, 32'h24);
    apb(1'b1, 8'hc0, 32'h20);
    pulse(9'h100);
    ticks(6);
    check(32'(irq.req), 32'h0);
    exp_q.push_back(16'h000b);
    apb(1'b1, 8'ha8, 32'hff);
    apb(1'b0, 8'ha8, 32'h0);
    check(rd, 32'hfb);
    wait_acks(1);
    ret_seq();
    apb(1'b1, 8'hac, 32'hff);
    apb(1'b0, 8'hac, 32'h0);
    check(rd, 32'h0e);
    lfsr = lfsr_next(lfsr);
    apb(1'b1, 8'hb8, lfsr);
    apb(1'b0, 8'hb8, 32'h0);
    check(rd, lfsr & 32'h7b);
    apb(1'b1, 8'hb8, 32'h0);
    // Every source once, group B twice to use both of its edges
    for (int i = 0; i < 10; i++) begin
      s = (i == 9) ? 8 : i;
      accept <= 1'b0;
      exp_q.push_back(EXPV[s]);
      @(posedge ref_clk);
      if (s == 0)
        ext_a_pin[2] <= 1'b1;
      else if (s == 8)
        ext_b_pin[1] <= ~ext_b_pin[1];
      else
        pulse(EVB[s]);
      wait_req();
      ticks(1);
      check(32'(irq.req), 32'h1);
      check(32'(wake), 32'(s == 0 || s >= 7));
      base = acks;
      accept <= 1'b1;
      wait_acks(base + 1);
      apb(1'b1, 8'hc8, 32'h3ff);
      ret_seq();
    end
    // Falling edge is not armed on this pin
    ext_a_pin[2] <= 1'b0;
    ticks(8);
    check(32'(irq.req), 32'h0);
    base = acks;
    exp_q.push_back(16'h000b);
    exp_q.push_back(16'h001b);
    exp_q.push_back(16'h004b);
    pulse(9'h181);
    for (int k = 1; k <= 3; k++) begin
      wait_acks(base + k);
      ret_seq();
    end
    apb(1'b1, 8'hb8, 32'h02);
    base = acks;
    exp_q.push_back(16'h001b);
    pulse(9'h080);
    wait_acks(base + 1);
    exp_q.push_back(16'h000b);
    pulse(9'h100);
    wait_acks(base + 2);
    pulse(9'h080);
    ticks(5);
    check(32'(irq.req), 32'h0);
    ret_seq();
    ticks(4);
    check(32'(irq.req), 32'h0);
    exp_q.push_back(16'h001b);
    ret_seq();
    wait_acks(base + 3);
    ret_seq();
    // Timer C stays pending until software clears it
    base = acks;
    exp_q.push_back(16'h002b);
    exp_q.push_back(16'h002b);
    pulse(9'h040);
    wait_acks(base + 1);
    ret_seq();
    wait_acks(base + 2);
    apb(1'b1, 8'hc8, 32'h20);
    ret_seq();
    ticks(6);
    check(32'(irq.req), 32'h0);
    check(32'(exp_q.size()), 32'h0);
    close_out();
  end
endmodule // test_two_level_interrupt_controller
`default_nettype wire

// File: tlic_core_model.sv
// Purpose: Behavioural core that answers the controller's vector requests
// Assumes: One-cycle ack pulse; accept lets the bench stall the core
// Notes: took and took_vec report each vector fetch to the bench monitor
`timescale 1ns/10ps
`default_nettype none
module tlic_core_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire tlic_pkg::tlic_irq_t irq,
  input wire logic accept,
  output logic irq_ack,
  output logic took,
  output logic [15:0] took_vec
);
  // ***********************
  // Vector fetch
  // ***********************
  // Never acks twice in a row, so one request yields one fetch
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_ack <= 1'b0;
      took <= 1'b0;
      took_vec <= 16'h0000;
    end else begin
      irq_ack <= accept & irq.req & ~irq_ack;
      took <= irq_ack & irq.req;
      if (irq_ack & irq.req) begin
        took_vec <= irq.vector;
      end
    end
  end
endmodule // tlic_core_model
`default_nettype wire

// File: tlic_pkg.sv
// Purpose: Constants and types for the two-level interrupt controller
// Assumes: APB byte addresses, registers of up to 10 bits in the low data bits
// Notes: Source index equals query order minus one
// Contract
// - Nine sources, each with its own high/low priority bit.
// - Request passes only with global enable bit 7 and source enable set.
// - Vectors: group A 0003, timer A 000B, timer B 001B.
// - Vectors: serial 0023, timer C 002B, converter 0033.
// - Vectors: pulse generator 0043, base tick 004B, group B 0053.
// - Only both pin groups and base tick wake from stop.
// - Timer A/B overflow sets flag; cleared by hardware on service.
// - Timer C flag set on overflow; only software clears it.
// - Serial rx/tx done flags set by hardware; only software clears.
// - Conversion start clears converter flag, completion sets it.
// - Pulse generator overflow sets flag; hardware clears on service.
// - Group A has 4 pins, group B 2; rise, fall or both.
// - High preempts low; equal or lower waits for return.
// - After return, one main instruction runs before next service.
// - Equal-priority simultaneous requests served in ascending query order.
// - Core finishes instruction, pushes counter, loads vector.
// - On return the core pops the counter and resumes.
// - Requests arriving during service stay pending, served later.
// - Main enable bits: conv 6, timer C 5, serial 4, B 3, A 1, group 0.
// - Main priority bits: conv 6, timer C 5, serial 4, timer B 3.
// - Main priority bits: timer A 1, group A 0; 1 is high.
// - Second enable/priority: group B 3, base tick 2, pulse 1.
// - Per-pin fall and rise arm bits; both set gives both edges.
// - Base tick flag cleared on service and by software.
package tlic_pkg;

  localparam int NSRC = 9;
  localparam int NFLAG = 10;

  // ***********************
  // Register byte offsets
  // ***********************
  localparam logic [7:0] OFS_IE = 8'ha8;
  localparam logic [7:0] OFS_IP = 8'hb8;
  localparam logic [7:0] OFS_IE2 = 8'hac;
  localparam logic [7:0] OFS_IP2 = 8'hbc;
  localparam logic [7:0] OFS_FALL = 8'hc0;
  localparam logic [7:0] OFS_RISE = 8'hc4;
  localparam logic [7:0] OFS_FLAG = 8'hc8;
  localparam logic [7:0] OFS_STAT = 8'hcc;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // Bit positions in the enable and priority registers
  localparam int GIE_BIT = 7;
  localparam int CONV_BIT = 6;
  localparam int TC_BIT = 5;
  localparam int SER_BIT = 4;
  localparam int TB_BIT = 3;
  localparam int TA_BIT = 1;
  localparam int EXTA_BIT = 0;
  localparam int EXTB_BIT = 3;
  localparam int BT_BIT = 2;
  localparam int PG_BIT = 1;

  // Source indices
  localparam logic [3:0] SRC_EXTA = 4'h0;
  localparam logic [3:0] SRC_TA = 4'h1;
  localparam logic [3:0] SRC_TB = 4'h2;
  localparam logic [3:0] SRC_SER = 4'h3;
  localparam logic [3:0] SRC_TC = 4'h4;

  // Flag bits
  localparam int F_EXTA = 0;
  localparam int F_TA = 1;
  localparam int F_TB = 2;
  localparam int F_RX = 3;
  localparam int F_TX = 4;
  localparam int F_TC = 5;
  localparam int F_CV = 6;
  localparam int F_PG = 7;
  localparam int F_BT = 8;
  localparam int F_EXTB = 9;
  localparam logic [NFLAG-1:0] AUTO_CLR = 10'h387;
  localparam logic [NSRC-1:0] WAKE_MASK = 9'h181;

  localparam logic [15:0] VEC [NSRC] = '{16'h0003, 16'h000b,
    16'h001b, 16'h0023, 16'h002b, 16'h0033, 16'h0043, 16'h004b,
    16'h0053};

  typedef enum logic [1:0] {
    TLIC_RUN = 2'b01,
    TLIC_HOLD = 2'b10
  } tlic_state_t;

  typedef struct packed {
    logic timer_a_ovf;
    logic timer_b_ovf;
    logic timer_c_ovf;
    logic rx_done;
    logic tx_done;
    logic conv_start;
    logic conv_done;
    logic pulse_ovf;
    logic base_tick_ovf;
  } tlic_evt_t;

  typedef struct packed {
    logic req;
    logic [15:0] vector;
  } tlic_irq_t;

  // Flag bits that make up one source
  function automatic logic [NFLAG-1:0] src_flags(input logic [3:0] s);
    if (s < SRC_SER) begin
      src_flags = 10'h001 << s;
    end else if (s == SRC_SER) begin
      src_flags = 10'h018;
    end else begin
      src_flags = 10'h001 << (s + 4'h1);
    end
  endfunction

endpackage

// File: tlic_top.sv
// Purpose: Two-level interrupt controller with APB register slave
// Assumes: Zero-wait APB; core pulses ack, return and instruction done
// Notes: Vector and request are registered; ack is taken only with req
//
// Our own choice: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module tlic_top #(
  parameter int NA = 4,
  parameter int NB = 2
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire tlic_pkg::tlic_evt_t evt,
  input wire logic [NA-1:0] ext_a_pin,
  input wire logic [NB-1:0] ext_b_pin,
  output tlic_pkg::tlic_irq_t irq,
  input wire logic irq_ack,
  input wire logic return_from_interrupt,
  input wire logic instr_done,
  output logic wake
);

  localparam int NP = NA + NB;
  localparam int NS = tlic_pkg::NSRC;

  logic [7:0] ie;
  logic [7:0] ip;
  logic [7:0] ie2;
  logic [7:0] ip2;
  logic [NP-1:0] rising_edge_arm;
  logic [NP-1:0] falling_edge_arm;
  logic [tlic_pkg::NFLAG-1:0] flag;
  logic [tlic_pkg::NFLAG-1:0] next_flag;
  logic [tlic_pkg::NFLAG-1:0] set_vec;
  logic [NS-1:0] pend;
  logic [NS-1:0] en;
  logic [NS-1:0] prio;
  logic [NS-1:0] elig;
  logic [NS-1:0] hi_c;
  logic [NS-1:0] lo_c;
  logic [NS-1:0] cand;
  logic next_found;
  logic next_lvl;
  logic [3:0] next_sel;
  logic [3:0] sel_q;
  logic lvl_q;
  logic hi_act;
  logic lo_act;
  logic ack_take;
  tlic_pkg::tlic_state_t state;
  logic [NP-1:0] pins;
  logic [NP-1:0] s1;
  logic [NP-1:0] s2;
  logic [NP-1:0] s3;
  logic [NP-1:0] edg;
  logic wr;
  logic wr_flag;
  logic hit;
  logic [31:0] rd_data;

  // *****************************
  // APB slave
  // *****************************
  assign pready = 1'b1;
  assign wr = psel && penable && pwrite;
  assign wr_flag = wr && (paddr == tlic_pkg::OFS_FLAG);

  always_comb begin
    hit = 1'b1;
    rd_data = '0;
    unique case (paddr)
      tlic_pkg::OFS_IE: rd_data[7:0] = ie;
      tlic_pkg::OFS_IP: rd_data[7:0] = ip;
      tlic_pkg::OFS_IE2: rd_data[7:0] = ie2;
      tlic_pkg::OFS_IP2: rd_data[7:0] = ip2;
      tlic_pkg::OFS_FALL: rd_data[NP-1:0] = falling_edge_arm;
      tlic_pkg::OFS_RISE: rd_data[NP-1:0] = rising_edge_arm;
      tlic_pkg::OFS_FLAG: rd_data[tlic_pkg::NFLAG-1:0] = flag;
      tlic_pkg::OFS_STAT: rd_data[7:0] = {state == tlic_pkg::TLIC_HOLD,
        hi_act, lo_act, irq.req, sel_q};
      default: hit = 1'b0;
    endcase
  end

  assign pslverr = psel && penable && !hit;

  // Read data is captured in the setup cycle so it is a flop output
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_data;
    end
  end

  // Reserved bits never store a one
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ie <= tlic_pkg::RST_BYTE;
      ip <= tlic_pkg::RST_BYTE;
      ie2 <= tlic_pkg::RST_BYTE;
      ip2 <= tlic_pkg::RST_BYTE;
      rising_edge_arm <= '0;
      falling_edge_arm <= '0;
    end else if (wr) begin
      unique case (paddr)
        tlic_pkg::OFS_IE: ie <= pwdata[7:0] & 8'hfb;
        tlic_pkg::OFS_IP: ip <= pwdata[7:0] & 8'h7b;
        tlic_pkg::OFS_IE2: ie2 <= pwdata[7:0] & 8'h0e;
        tlic_pkg::OFS_IP2: ip2 <= pwdata[7:0] & 8'h0e;
        tlic_pkg::OFS_FALL: falling_edge_arm <= pwdata[NP-1:0];
        tlic_pkg::OFS_RISE: rising_edge_arm <= pwdata[NP-1:0];
        default: ;
      endcase
    end
  end

  // *****************************
  // Pin synchronisers and edges
  // *****************************
  assign pins = {ext_b_pin, ext_a_pin};

  for (genvar g = 0; g < NP; g++) begin : g_pin
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        s1[g] <= 1'b0;
        s2[g] <= 1'b0;
        s3[g] <= 1'b0;
      end else begin
        s1[g] <= pins[g];
        s2[g] <= s1[g];
        s3[g] <= s2[g];
      end
    end
    assign edg[g] = (rising_edge_arm[g] && s2[g] && !s3[g])
      || (falling_edge_arm[g] && !s2[g] && s3[g]);
  end

  // *****************************
  // Flags
  // *****************************
  always_comb begin
    set_vec = '0;
    set_vec[tlic_pkg::F_EXTA] = |edg[NA-1:0];
    set_vec[tlic_pkg::F_EXTB] = |edg[NP-1:NA];
    set_vec[tlic_pkg::F_TA] = evt.timer_a_ovf;
    set_vec[tlic_pkg::F_TB] = evt.timer_b_ovf;
    set_vec[tlic_pkg::F_TC] = evt.timer_c_ovf;
    set_vec[tlic_pkg::F_RX] = evt.rx_done;
    set_vec[tlic_pkg::F_TX] = evt.tx_done;
    set_vec[tlic_pkg::F_CV] = evt.conv_done;
    set_vec[tlic_pkg::F_PG] = evt.pulse_ovf;
    set_vec[tlic_pkg::F_BT] = evt.base_tick_ovf;
  end

  // Sets are applied last so an event in a clear cycle is kept
  always_comb begin
    next_flag = flag;
    if (wr_flag) begin
      next_flag = next_flag & ~pwdata[tlic_pkg::NFLAG-1:0];
    end
    if (ack_take) begin
      next_flag = next_flag
        & ~(tlic_pkg::src_flags(sel_q) & tlic_pkg::AUTO_CLR);
    end
    if (evt.conv_start) begin
      next_flag[tlic_pkg::F_CV] = 1'b0;
    end
    next_flag = next_flag | set_vec;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flag <= '0;
    end else begin
      flag <= next_flag;
    end
  end

  // *****************************
  // Gating and selection
  // *****************************
  always_comb begin
    en = {ie2[tlic_pkg::EXTB_BIT], ie2[tlic_pkg::BT_BIT],
      ie2[tlic_pkg::PG_BIT], ie[tlic_pkg::CONV_BIT], ie[tlic_pkg::TC_BIT],
      ie[tlic_pkg::SER_BIT], ie[tlic_pkg::TB_BIT], ie[tlic_pkg::TA_BIT],
      ie[tlic_pkg::EXTA_BIT]};
    prio = {ip2[tlic_pkg::EXTB_BIT], ip2[tlic_pkg::BT_BIT],
      ip2[tlic_pkg::PG_BIT], ip[tlic_pkg::CONV_BIT], ip[tlic_pkg::TC_BIT],
      ip[tlic_pkg::SER_BIT], ip[tlic_pkg::TB_BIT], ip[tlic_pkg::TA_BIT],
      ip[tlic_pkg::EXTA_BIT]};
    for (int i = 0; i < NS; i++) begin
      pend[i] = |(flag & tlic_pkg::src_flags(4'(i)));
    end
  end

  assign elig = pend & en & {NS{ie[tlic_pkg::GIE_BIT]}};
  assign hi_c = elig & prio;
  assign lo_c = elig & ~prio;

  // A running level blocks its own level and any lower one
  always_comb begin
    cand = '0;
    next_lvl = 1'b0;
    next_found = 1'b0;
    next_sel = '0;
    if (!hi_act && |hi_c) begin
      cand = hi_c;
      next_lvl = 1'b1;
    end else if (!hi_act && !lo_act) begin
      cand = lo_c;
    end
    for (int i = NS - 1; i >= 0; i--) begin
      if (cand[i]) begin
        next_found = 1'b1;
        next_sel = 4'(i);
      end
    end
  end

  assign ack_take = irq_ack && irq.req;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq <= '0;
      sel_q <= '0;
      lvl_q <= 1'b0;
    end else begin
      irq.req <= next_found && (state == tlic_pkg::TLIC_RUN)
        && !ack_take && !return_from_interrupt;
      irq.vector <= tlic_pkg::VEC[next_sel];
      sel_q <= next_sel;
      lvl_q <= next_lvl;
    end
  end

  // *****************************
  // In-service levels and return
  // *****************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hi_act <= 1'b0;
      lo_act <= 1'b0;
    end else if (ack_take) begin
      if (lvl_q) begin
        hi_act <= 1'b1;
      end else begin
        lo_act <= 1'b1;
      end
    end else if (return_from_interrupt) begin
      if (hi_act) begin
        hi_act <= 1'b0;
      end else begin
        lo_act <= 1'b0;
      end
    end
  end

  // One main instruction must retire before the next service
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= tlic_pkg::TLIC_RUN;
    end else begin
      unique case (state)
        tlic_pkg::TLIC_RUN: begin
          if (return_from_interrupt) begin
            state <= tlic_pkg::TLIC_HOLD;
          end
        end
        tlic_pkg::TLIC_HOLD: begin
          if (instr_done) begin
            state <= tlic_pkg::TLIC_RUN;
          end
        end
        default: state <= tlic_pkg::TLIC_RUN;
      endcase
    end
  end

  // Stop-mode wake ignores the in-service levels on purpose
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wake <= 1'b0;
    end else begin
      wake <= |(elig & tlic_pkg::WAKE_MASK);
    end
  end

  // *****************************
  // Assertions
  // *****************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  a_global_gate: assert property (
    !ie[tlic_pkg::GIE_BIT] |=> !irq.req)
    else $error("request with global enable off");

  a_vector_map: assert property (
    irq.req |-> irq.vector == tlic_pkg::VEC[sel_q])
    else $error("vector does not match source");

  a_timer_autoclr: assert property (
    ack_take && sel_q == tlic_pkg::SRC_TA && !evt.timer_a_ovf
    |=> !flag[tlic_pkg::F_TA])
    else $error("timer A flag not cleared on service");

  a_timer_c_kept: assert property (
    ack_take && sel_q == tlic_pkg::SRC_TC && !wr_flag
    |=> flag[tlic_pkg::F_TC])
    else $error("timer C flag cleared by hardware");

  a_serial_kept: assert property (
    flag[tlic_pkg::F_RX] && !wr_flag |=> flag[tlic_pkg::F_RX])
    else $error("rx flag lost without software clear");

  a_conv_start: assert property (
    evt.conv_start && !evt.conv_done |=> !flag[tlic_pkg::F_CV])
    else $error("converter flag not cleared on start");

  a_edge_pend: assert property (
    |edg[NA-1:0] |=> flag[tlic_pkg::F_EXTA])
    else $error("group A edge not recorded");

  a_nest_block: assert property (
    hi_act && $past(hi_act) |-> !irq.req)
    else $error("request during high-level service");

  a_one_instr: assert property (
    return_from_interrupt |=> !irq.req ##1 !irq.req)
    else $error("request too soon after return");

  a_query_order: assert property (
    irq.req |-> ($past(cand) & ((9'h001 << sel_q) - 9'h001)) == 9'h000)
    else $error("lower query number skipped");

  c_high_preempt: cover property (lo_act ##1 ack_take && lvl_q);
  c_return_hold: cover property (return_from_interrupt ##[1:4] instr_done);
  c_wake: cover property ($rose(wake));

endmodule // tlic_top
`default_nettype wire
